// ==== logic/clkctl_pkg.sv ====
// Purpose: shared constants and types for the clock control block
// Assumes: MCLK at 20 MHz; frequencies are carried as integer kHz
// Notes:   strap defaults live here so the top and any checker agree
package clkctl_pkg;

    // ***********************************************************
    // widths
    // ***********************************************************
    localparam int OSC_W  = 17;   // oscillator kHz, up to 100 MHz
    localparam int PROD_W = 30;   // osc kHz times (loop gain + 1)
    localparam int DEN_W  = 11;   // 2 * (pre + 1) * (post + 1), up to 1024
    localparam int POST_W = 3;
    localparam int GAIN_W = 12;
    localparam int PRE_W  = 6;
    localparam int CNT_W  = 32;

    // ***********************************************************
    // strap codes {hi, lo} and oscillator figures
    // ***********************************************************
    localparam logic [1:0] STRAP_5_13   = 2'h0;
    localparam logic [1:0] STRAP_48_100 = 2'h1;
    localparam logic [1:0] STRAP_20_48  = 2'h2;
    localparam logic [1:0] STRAP_13_20  = 2'h3;

    localparam logic [OSC_W-1:0]  ONCHIP_OSC_KHZ = 17'h0_4E20;     // 20 MHz
    localparam logic [PROD_W-1:0] IF_MIN_KHZ     = 30'h0003_F7A0;  // 260 MHz
    localparam logic [PROD_W-1:0] IF_MAX_KHZ     = 30'h0013_D620;  // 1.3 GHz

    // ***********************************************************
    // timing
    // ***********************************************************
    localparam int MCLK_PERIOD_NS  = 50;
    localparam int MCLK_HZ         = 1000000000 / MCLK_PERIOD_NS;
    localparam int REF_DEFAULT_MHZ = 100;
    localparam int TIMER_TICK_NS   = 1000 / REF_DEFAULT_MHZ;
    localparam int TIMER_STEP_INT  = MCLK_PERIOD_NS / TIMER_TICK_NS;
    localparam logic [CNT_W-1:0] TIMER_STEP = CNT_W'(TIMER_STEP_INT);
    localparam int SLOW_OSC_HZ     = 31250;
    localparam int SLOW_OSC_DIV    = MCLK_HZ / SLOW_OSC_HZ;
    localparam int INTRST_DEFAULT  = 750000;

    // ***********************************************************
    // pll settings
    // ***********************************************************
    typedef struct packed {
        logic [POST_W-1:0] post;
        logic [GAIN_W-1:0] gain;
        logic [PRE_W-1:0]  pre;
    } clkctl_pll_s;

    localparam clkctl_pll_s PLL_RESET = '{post: 3'h1, gain: 12'h07A, pre: 6'h00};

    // default post/gain/pre per strap code
    function automatic clkctl_pll_s clkctl_default(input logic [1:0] code);
        clkctl_pll_s s;
        s = PLL_RESET;
        unique case (code)
            STRAP_5_13:   s = '{post: 3'h1, gain: 12'h07A, pre: 6'h00};
            STRAP_13_20:  s = '{post: 3'h2, gain: 12'h077, pre: 6'h00};
            STRAP_20_48:  s = '{post: 3'h2, gain: 12'h031, pre: 6'h00};
            STRAP_48_100: s = '{post: 3'h2, gain: 12'h017, pre: 6'h00};
        endcase
        return s;
    endfunction

endpackage

// ==== logic/clkctl_div_if.sv ====
// Purpose: request and answer wires between the top and its divider
// Assumes: one request at a time; start only while idle
// Notes:   done is a one-cycle pulse with quotient valid alongside
`timescale 1ns/1ns
interface clkctl_div_if;
    import clkctl_pkg::*;
    logic              start;
    logic [PROD_W-1:0] dividend;
    logic [DEN_W-1:0]  divisor;
    logic              done;
    logic [PROD_W-1:0] quotient;

    modport req  (output start, output dividend, output divisor,
                  input done, input quotient);
    modport calc (input start, input dividend, input divisor,
                  output done, output quotient);
endinterface

// ==== logic/clkctl_div.sv ====
// Purpose: restoring divider used to work out pll frequencies
// Assumes: divisor never zero; start ignored while busy
// Notes:   one quotient bit per cycle, PROD_W cycles per answer
`timescale 1ns/1ns
module clkctl_div
    import clkctl_pkg::*;
(
    input  wire logic   MCLK,
    input  wire logic   NRST,
    clkctl_div_if.calc  div
);

    // ***********************************************************
    // state
    // ***********************************************************
    logic              busy_ff, nxt_busy;
    logic              done_ff, nxt_done;
    logic [4:0]        cnt_ff,  nxt_cnt;
    logic [DEN_W-1:0]  rem_ff,  nxt_rem;
    logic [DEN_W-1:0]  den_ff,  nxt_den;
    logic [PROD_W-1:0] quo_ff,  nxt_quo;
    logic [DEN_W:0]    shifted;

    // shift in one dividend bit, subtract when it fits
    always_comb begin
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_cnt  = cnt_ff;
        nxt_rem  = rem_ff;
        nxt_den  = den_ff;
        nxt_quo  = quo_ff;
        shifted  = {rem_ff, quo_ff[PROD_W-1]};
        if (div.start && !busy_ff) begin
            nxt_busy = 1'b1;
            nxt_cnt  = 5'(PROD_W - 1);
            nxt_rem  = '0;
            nxt_den  = div.divisor;
            nxt_quo  = div.dividend;
        end else if (busy_ff) begin
            if (shifted >= {1'b0, den_ff}) begin
                nxt_rem = DEN_W'(shifted - {1'b0, den_ff});
                nxt_quo = {quo_ff[PROD_W-2:0], 1'b1};
            end else begin
                nxt_rem = shifted[DEN_W-1:0];
                nxt_quo = {quo_ff[PROD_W-2:0], 1'b0};
            end
            if (cnt_ff == '0) begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
            end else begin
                nxt_cnt = cnt_ff - 5'h1;
            end
        end
    end

    // registers only
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            cnt_ff  <= '0;
            rem_ff  <= '0;
            den_ff  <= '0;
            quo_ff  <= '0;
        end else begin
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            cnt_ff  <= nxt_cnt;
            rem_ff  <= nxt_rem;
            den_ff  <= nxt_den;
            quo_ff  <= nxt_quo;
        end
    end

    assign div.done     = done_ff;
    assign div.quotient = quo_ff;

endmodule

// ==== logic/clkctl_tick.sv ====
// Purpose: divides MCLK into a one-cycle enable pulse
// Assumes: DIV of at least 2
// Notes:   stands in for the slow low-power oscillator
`timescale 1ns/1ns
module clkctl_tick #(
    parameter int DIV = 640
) (
    input  wire logic MCLK,
    input  wire logic NRST,
    input  wire logic RUN,
    output logic      TICK
);

    // ***********************************************************
    // counter
    // ***********************************************************
    logic [15:0] cnt_ff, nxt_cnt;
    logic        tick_ff, nxt_tick;

    // count down, pulse on wrap
    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_tick = 1'b0;
        if (RUN) begin
            if (cnt_ff == '0) begin
                nxt_cnt  = 16'(DIV - 1);
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff - 16'h0001;
            end
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign TICK = tick_ff;

endmodule

// ==== logic/clkctl_top.sv ====
// Purpose: oscillator select, pll settings, boot hold-off and timers
// Assumes: straps steady around reset release; pll writes kept in range
// Notes:   frequencies are reported in kHz, pll clocks are not synthesised
`timescale 1ns/1ns
module clkctl_top
    import clkctl_pkg::*;
#(
    parameter int INTRST_CYCLES = INTRST_DEFAULT
) (
    input  wire logic                         MCLK,
    input  wire logic                         NRST,
    input  wire logic                         OSCILLATOR_SOURCE_SELECT_N,
    input  wire logic                         CLOCK_RANGE_STRAP_LO,
    input  wire logic                         CLOCK_RANGE_STRAP_HI,
    input  wire logic [clkctl_pkg::OSC_W-1:0] CRYSTAL_CLOCK_INPUT_KHZ,
    input  wire logic                         LOW_POWER,
    input  wire logic                         PLL_WR,
    input  wire logic [clkctl_pkg::POST_W-1:0] PLL_WR_POST_SCALE,
    input  wire logic [clkctl_pkg::GAIN_W-1:0] PLL_WR_LOOP_GAIN,
    input  wire logic [clkctl_pkg::PRE_W-1:0] PLL_WR_PRE_SCALE,
    output logic                              BOOT_DONE,
    output logic                              OSC_IS_ONCHIP,
    output logic [1:0]                        STRAP_CODE,
    output logic [clkctl_pkg::OSC_W-1:0]      OSC_FREQ_KHZ,
    output logic [clkctl_pkg::OSC_W-1:0]      ANALOG_FREQ_KHZ,
    output logic [clkctl_pkg::POST_W-1:0]     PLL_POST_SCALE,
    output logic [clkctl_pkg::GAIN_W-1:0]     PLL_LOOP_GAIN,
    output logic [clkctl_pkg::PRE_W-1:0]      PLL_PRE_SCALE,
    output logic [clkctl_pkg::PROD_W-1:0]     IF_FREQ_KHZ,
    output logic [clkctl_pkg::PROD_W-1:0]     TILE_FREQ_KHZ,
    output logic                              FREQ_VALID,
    output logic                              PLL_RANGE_ERR,
    output logic [clkctl_pkg::CNT_W-1:0]      TIMER_VALUE,
    output logic [clkctl_pkg::CNT_W-1:0]      RTC_VALUE,
    output logic                              SLOW_OSC_TICK
);

    // ***********************************************************
    // declarations
    // ***********************************************************
    typedef enum logic [2:0] {
        ST_SAMPLE = 3'b001,
        ST_HOLD   = 3'b010,
        ST_RUN    = 3'b100
    } clkctl_boot_e;

    typedef enum logic [2:0] {
        CS_IDLE = 3'b001,
        CS_IF   = 3'b010,
        CS_TILE = 3'b100
    } clkctl_calc_e;

    clkctl_boot_e      boot_ff, nxt_boot;
    logic [31:0]       hold_ff, nxt_hold;
    logic              onchip_ff, nxt_onchip;
    logic [1:0]        strap_ff, nxt_strap;
    logic [OSC_W-1:0]  osc_ff, nxt_osc;
    clkctl_pll_s       pll_ff, nxt_pll;
    logic              pend_ff, nxt_pend;

    clkctl_calc_e      calc_ff, nxt_calc;
    logic [PROD_W-1:0] if_ff, nxt_if;
    logic [PROD_W-1:0] tile_ff, nxt_tile;
    logic              valid_ff, nxt_valid;
    logic              err_ff, nxt_err;
    logic              start_ff, nxt_start;
    logic [PROD_W-1:0] dvd_ff, nxt_dvd;
    logic [DEN_W-1:0]  dvs_ff, nxt_dvs;
    logic [DEN_W-1:0]  post_den_ff, nxt_post_den;

    logic [CNT_W-1:0]  timer_ff, nxt_timer;
    logic [CNT_W-1:0]  rtc_ff, nxt_rtc;
    logic              slow_tick;

    clkctl_div_if div_bus ();

    // ***********************************************************
    // boot sequence and pll settings
    // ***********************************************************

    // sample straps once after release, then hold off boot
    always_comb begin
        nxt_boot   = boot_ff;
        nxt_hold   = hold_ff;
        nxt_onchip = onchip_ff;
        nxt_strap  = strap_ff;
        nxt_osc    = osc_ff;
        nxt_pll    = pll_ff;
        nxt_pend   = pend_ff;
        unique case (boot_ff)
            ST_SAMPLE: begin
                nxt_onchip = OSCILLATOR_SOURCE_SELECT_N;
                nxt_osc    = OSCILLATOR_SOURCE_SELECT_N ? ONCHIP_OSC_KHZ
                                                        : CRYSTAL_CLOCK_INPUT_KHZ;
                // straps read here only: later changes are not seen
                nxt_strap  = {CLOCK_RANGE_STRAP_HI, CLOCK_RANGE_STRAP_LO};
                nxt_pll    = clkctl_default(nxt_strap);
                nxt_pend   = 1'b1;
                nxt_hold   = 32'(INTRST_CYCLES - 1);
                nxt_boot   = ST_HOLD;
            end
            ST_HOLD: begin
                if (hold_ff == '0) begin
                    nxt_boot = ST_RUN;
                end else begin
                    nxt_hold = hold_ff - 32'h0000_0001;
                end
            end
            ST_RUN: begin
                nxt_boot = ST_RUN;
            end
        endcase
        // writes taken once straps are loaded; fields arrive already in range
        if (boot_ff != ST_SAMPLE && PLL_WR) begin
            nxt_pll.post = PLL_WR_POST_SCALE;
            nxt_pll.gain = PLL_WR_LOOP_GAIN;
            nxt_pll.pre  = PLL_WR_PRE_SCALE;
            nxt_pend     = 1'b1;
        end else if (calc_ff == CS_IDLE && pend_ff && boot_ff != ST_SAMPLE) begin
            nxt_pend = 1'b0;   // a write in this cycle keeps it set above
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            boot_ff   <= ST_SAMPLE;
            hold_ff   <= '0;
            onchip_ff <= 1'b0;
            strap_ff  <= STRAP_5_13;
            osc_ff    <= '0;
            pll_ff    <= PLL_RESET;
            pend_ff   <= 1'b0;
        end else begin
            boot_ff   <= nxt_boot;
            hold_ff   <= nxt_hold;
            onchip_ff <= nxt_onchip;
            strap_ff  <= nxt_strap;
            osc_ff    <= nxt_osc;
            pll_ff    <= nxt_pll;
            pend_ff   <= nxt_pend;
        end
    end

    // ***********************************************************
    // frequency calculation
    // ***********************************************************

    // two passes on one divider: intermediate, then tile
    // sharing the divider trades about 32 cycles of latency, one extra pass, for area
    always_comb begin
        nxt_calc     = calc_ff;
        nxt_if       = if_ff;
        nxt_tile     = tile_ff;
        nxt_valid    = valid_ff;
        nxt_err      = err_ff;
        nxt_start    = 1'b0;
        nxt_dvd      = dvd_ff;
        nxt_dvs      = dvs_ff;
        nxt_post_den = post_den_ff;
        unique case (calc_ff)
            CS_IDLE: begin
                if (pend_ff && boot_ff != ST_SAMPLE) begin
                    nxt_valid    = 1'b0;
                    nxt_start    = 1'b1;
                    nxt_dvd      = PROD_W'(osc_ff * ({1'b0, pll_ff.gain} + 13'h0001));
                    nxt_dvs      = DEN_W'({pll_ff.pre, 1'b0} + 7'h02);
                    nxt_post_den = DEN_W'(({pll_ff.pre, 1'b0} + 7'h02)
                                          * ({1'b0, pll_ff.post} + 4'h1));
                    nxt_calc     = CS_IF;
                end
            end
            CS_IF: begin
                if (div_bus.done) begin
                    nxt_if    = div_bus.quotient;
                    // out-of-range settings are flagged, never corrected
                    nxt_err   = (div_bus.quotient < IF_MIN_KHZ) ||
                                (div_bus.quotient > IF_MAX_KHZ);
                    nxt_start = 1'b1;
                    nxt_dvs   = post_den_ff;
                    nxt_calc  = CS_TILE;
                end
            end
            CS_TILE: begin
                if (div_bus.done) begin
                    nxt_tile  = div_bus.quotient;
                    nxt_valid = !pend_ff;
                    nxt_calc  = CS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            calc_ff     <= CS_IDLE;
            if_ff       <= '0;
            tile_ff     <= '0;
            valid_ff    <= 1'b0;
            err_ff      <= 1'b0;
            start_ff    <= 1'b0;
            dvd_ff      <= '0;
            dvs_ff      <= '0;
            post_den_ff <= '0;
        end else begin
            calc_ff     <= nxt_calc;
            if_ff       <= nxt_if;
            tile_ff     <= nxt_tile;
            valid_ff    <= nxt_valid;
            err_ff      <= nxt_err;
            start_ff    <= nxt_start;
            dvd_ff      <= nxt_dvd;
            dvs_ff      <= nxt_dvs;
            post_den_ff <= nxt_post_den;
        end
    end

    assign div_bus.start    = start_ff;
    assign div_bus.dividend = dvd_ff;
    assign div_bus.divisor  = dvs_ff;

    clkctl_div u_div (
        .MCLK (MCLK),
        .NRST (NRST),
        .div  (div_bus.calc)
    );

    // ***********************************************************
    // processor timer and real-time counter
    // ***********************************************************

    // slow oscillator modelled as an enable from MCLK
    clkctl_tick #(
        .DIV (SLOW_OSC_DIV)
    ) u_slow (
        .MCLK (MCLK),
        .NRST (NRST),
        .RUN  (boot_ff != ST_SAMPLE),
        .TICK (slow_tick)
    );

    // timer counts 10 ns units of the 100 MHz reference
    always_comb begin
        nxt_timer = timer_ff;
        nxt_rtc   = rtc_ff;
        if (boot_ff == ST_RUN) begin
            nxt_timer = timer_ff + TIMER_STEP;
        end
        if (boot_ff != ST_SAMPLE) begin
            if (LOW_POWER) begin
                nxt_rtc = slow_tick ? rtc_ff + 32'h0000_0001 : rtc_ff;
            end else begin
                nxt_rtc = rtc_ff + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            timer_ff <= '0;
            rtc_ff   <= '0;
        end else begin
            timer_ff <= nxt_timer;
            rtc_ff   <= nxt_rtc;
        end
    end

    // ***********************************************************
    // outputs
    // ***********************************************************
    assign BOOT_DONE       = (boot_ff == ST_RUN);
    assign OSC_IS_ONCHIP   = onchip_ff;
    assign STRAP_CODE      = strap_ff;
    assign OSC_FREQ_KHZ    = osc_ff;
    assign ANALOG_FREQ_KHZ = osc_ff;       // no pll on the analog side
    assign PLL_POST_SCALE  = pll_ff.post;
    assign PLL_LOOP_GAIN   = pll_ff.gain;
    assign PLL_PRE_SCALE   = pll_ff.pre;
    assign IF_FREQ_KHZ     = if_ff;
    assign TILE_FREQ_KHZ   = tile_ff;
    assign FREQ_VALID      = valid_ff;
    assign PLL_RANGE_ERR   = err_ff;
    assign TIMER_VALUE     = timer_ff;
    assign RTC_VALUE       = rtc_ff;
    assign SLOW_OSC_TICK   = slow_tick;

endmodule

// ==== tb/clkctl_props.sv ====
// Purpose: port-level assertions for clkctl_top
// Assumes: one MCLK domain, NRST async active low
// Notes:   boot count follows the top's INTRST_CYCLES
`timescale 1ns/1ns
module clkctl_props
    import clkctl_pkg::*;
#(
    parameter int INTRST_CYCLES = 20
) (
    input wire logic                          MCLK,
    input wire logic                          NRST,
    input wire logic                          LOW_POWER,
    input wire logic                          PLL_WR,
    input wire logic [clkctl_pkg::POST_W-1:0] PLL_WR_POST_SCALE,
    input wire logic [clkctl_pkg::GAIN_W-1:0] PLL_WR_LOOP_GAIN,
    input wire logic [clkctl_pkg::PRE_W-1:0]  PLL_WR_PRE_SCALE,
    input wire logic                          BOOT_DONE,
    input wire logic                          OSC_IS_ONCHIP,
    input wire logic [1:0]                    STRAP_CODE,
    input wire logic [clkctl_pkg::OSC_W-1:0]  OSC_FREQ_KHZ,
    input wire logic [clkctl_pkg::OSC_W-1:0]  ANALOG_FREQ_KHZ,
    input wire logic [clkctl_pkg::POST_W-1:0] PLL_POST_SCALE,
    input wire logic [clkctl_pkg::GAIN_W-1:0] PLL_LOOP_GAIN,
    input wire logic [clkctl_pkg::PRE_W-1:0]  PLL_PRE_SCALE,
    input wire logic [clkctl_pkg::PROD_W-1:0] IF_FREQ_KHZ,
    input wire logic [clkctl_pkg::PROD_W-1:0] TILE_FREQ_KHZ,
    input wire logic                          FREQ_VALID,
    input wire logic                          PLL_RANGE_ERR,
    input wire logic [clkctl_pkg::CNT_W-1:0]  TIMER_VALUE,
    input wire logic [clkctl_pkg::CNT_W-1:0]  RTC_VALUE
);
    // ***********************************************************
    // edges since release, frozen at boot
    // ***********************************************************
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    always_comb nxt_cnt = BOOT_DONE ? cnt_ff : cnt_ff + 32'h0000_0001;
    always_ff @(posedge MCLK or negedge NRST) cnt_ff <= !NRST ? '0 : nxt_cnt;

    // 64 bits so a full loop gain cannot wrap the product
    function automatic longint f_calc(input longint o, g, r, d);
        return o * (g + 1) / (2 * (r + 1) * (d + 1));
    endfunction

    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    sequence s_drop; ##[1:3] !FREQ_VALID; endsequence
    sequence s_rise; ##[1:80] FREQ_VALID; endsequence

    a_boot_count: assert property ($rose(BOOT_DONE) |-> cnt_ff == INTRST_CYCLES + 1)
        else $error("boot done at wrong count");
    a_boot_held: assert property (BOOT_DONE |=> BOOT_DONE)
        else $error("boot done dropped");
    a_strap_held: assert property (cnt_ff != 0 |=> $stable(STRAP_CODE) && $stable(OSC_FREQ_KHZ))
        else $error("straps resampled");
    a_write_taken: assert property (PLL_WR && cnt_ff != 0 |=> PLL_LOOP_GAIN == $past(PLL_WR_LOOP_GAIN) && PLL_POST_SCALE == $past(PLL_WR_POST_SCALE) && PLL_PRE_SCALE == $past(PLL_WR_PRE_SCALE))
        else $error("pll write not taken");
    a_settings_hold: assert property (!PLL_WR && cnt_ff != 0 |=> $stable(PLL_LOOP_GAIN) && $stable(PLL_POST_SCALE) && $stable(PLL_PRE_SCALE))
        else $error("pll settings moved");
    a_calc_cycle: assert property (PLL_WR && !$past(PLL_WR) && FREQ_VALID && cnt_ff != 0 ##1 !PLL_WR |-> s_drop ##0 s_rise)
        else $error("recalculation missing");
    a_tile_calc: assert property ($rose(FREQ_VALID) |-> TILE_FREQ_KHZ == f_calc(OSC_FREQ_KHZ, PLL_LOOP_GAIN, PLL_PRE_SCALE, PLL_POST_SCALE))
        else $error("tile frequency wrong");
    a_if_range: assert property ($rose(FREQ_VALID) |-> PLL_RANGE_ERR == (IF_FREQ_KHZ < IF_MIN_KHZ || IF_FREQ_KHZ > IF_MAX_KHZ))
        else $error("range flag wrong");
    a_analog_osc: assert property (ANALOG_FREQ_KHZ == OSC_FREQ_KHZ)
        else $error("analog clock differs");
    a_onchip_freq: assert property (OSC_IS_ONCHIP |-> OSC_FREQ_KHZ == ONCHIP_OSC_KHZ)
        else $error("onchip frequency wrong");
    a_timer_step: assert property (BOOT_DONE && $past(BOOT_DONE) |-> TIMER_VALUE == $past(TIMER_VALUE) + 5)
        else $error("timer step wrong");
    a_rtc_count: assert property (!LOW_POWER && cnt_ff > 1 |=> RTC_VALUE == $past(RTC_VALUE) + 1)
        else $error("rtc step wrong");
endmodule
bind clkctl_top clkctl_props #(.INTRST_CYCLES(INTRST_CYCLES)) props_u (.*);

// ==== tb/clkctl_board.sv ====
// Purpose: board straps and resonator in front of the block
// Assumes: settings change only while reset is held
// Notes:   lines start settled so no input is unknown
`timescale 1ns/1ns
module clkctl_board
    import clkctl_pkg::*;
(
    input  wire logic                         MCLK,
    input  wire logic                         NRST,
    input  wire logic                         want_onchip,
    input  wire logic [1:0]                   want_code,
    input  wire logic [clkctl_pkg::OSC_W-1:0] want_khz,
    output logic                              source_n = 1'b0,
    output logic                              strap_lo = 1'b0,
    output logic                              strap_hi = 1'b0,
    output logic [clkctl_pkg::OSC_W-1:0]      crystal_khz = '0
);
    // board levels move only in reset, so release sees them steady
    always @(negedge MCLK) begin
        if (!NRST) begin
            source_n <= want_onchip;
            {strap_hi, strap_lo} <= want_code;
            crystal_khz <= want_khz;
        end
    end
endmodule

// ==== tb/clkctl_bench.sv ====
// Purpose: self-checking bench for clkctl_top
// Assumes: boot hold shortened to 20 cycles
// Notes:   inputs move on the falling edge
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %0d got %0d", nm, e, g); end end
module clkctl_bench;
    import clkctl_pkg::*;
    localparam int NCYC = 20;
    logic mclk = 1'b0, nrst = 1'b0, lp = 1'b0, wr = 1'b0, w_oc = 1'b0;
    logic [POST_W-1:0] wpost = '0, post;
    logic [GAIN_W-1:0] wgain = '0, gain;
    logic [PRE_W-1:0] wpre = '0, pre;
    logic [1:0] w_cd = '0, code;
    logic [OSC_W-1:0] w_khz = '0, xkhz, osc, ana;
    logic src_n, s_lo, s_hi, boot, oc, valid, rerr, tick;
    logic [PROD_W-1:0] ifk, tile;
    logic [CNT_W-1:0] timer, rtc, t0, r0;
    int errors = 0, cmp_count = 0, cur_osc;

    // ***********************************************************
    // design, board and clock
    // ***********************************************************
    clkctl_board board_u (.MCLK(mclk), .NRST(nrst), .want_onchip(w_oc), .want_code(w_cd),
        .want_khz(w_khz), .source_n(src_n), .strap_lo(s_lo), .strap_hi(s_hi), .crystal_khz(xkhz));
    clkctl_top #(.INTRST_CYCLES(NCYC)) dut_u (.MCLK(mclk), .NRST(nrst),
        .OSCILLATOR_SOURCE_SELECT_N(src_n), .CLOCK_RANGE_STRAP_LO(s_lo),
        .CLOCK_RANGE_STRAP_HI(s_hi), .CRYSTAL_CLOCK_INPUT_KHZ(xkhz), .LOW_POWER(lp),
        .PLL_WR(wr), .PLL_WR_POST_SCALE(wpost), .PLL_WR_LOOP_GAIN(wgain),
        .PLL_WR_PRE_SCALE(wpre), .BOOT_DONE(boot), .OSC_IS_ONCHIP(oc), .STRAP_CODE(code),
        .OSC_FREQ_KHZ(osc), .ANALOG_FREQ_KHZ(ana), .PLL_POST_SCALE(post), .PLL_LOOP_GAIN(gain),
        .PLL_PRE_SCALE(pre), .IF_FREQ_KHZ(ifk), .TILE_FREQ_KHZ(tile), .FREQ_VALID(valid),
        .PLL_RANGE_ERR(rerr), .TIMER_VALUE(timer), .RTC_VALUE(rtc), .SLOW_OSC_TICK(tick));
    initial forever #25 mclk = ~mclk;

    function automatic int calc(input int o, g, r, d);
        return int'(longint'(o) * (g + 1) / (2 * (r + 1) * (d + 1)));
    endfunction

    // waits for the result, then checks it against the settings
    task check_res(input int g, r, d);
        int n;
        n = 0;
        while (valid !== 1'b1 && n < 200) begin @(negedge mclk); n++; end
        `CHK("valid", 1'b1, valid)
        `CHK("if", calc(cur_osc, g, r, 0), ifk)
        `CHK("tile", calc(cur_osc, g, r, d), tile)
        `CHK("range", (calc(cur_osc, g, r, 0) < IF_MIN_KHZ || calc(cur_osc, g, r, 0) > IF_MAX_KHZ), rerr)
    endtask

    // reset, optional write at the first edge, boot count and defaults
    task do_boot(input logic c_oc, input logic [1:0] c_cd, input int khz, input logic ew,
                 input int ep, input int eg);
        int n;
        w_oc = c_oc; w_cd = c_cd; w_khz = khz[OSC_W-1:0];
        cur_osc = c_oc ? 20000 : khz;
        nrst = 1'b0;
        repeat (20) @(negedge mclk);
        `CHK("rst_gain", 12'h07A, gain)
        nrst = 1'b1; wr = ew; wpost = 3'h7; wgain = 12'h0001; wpre = 6'h01;
        @(negedge mclk);
        wr = 1'b0;
        `CHK("code", c_cd, code)
        `CHK("onchip", c_oc, oc)
        `CHK("osc", cur_osc, osc)
        `CHK("analog", cur_osc, ana)
        `CHK("post", ep, post)
        `CHK("gain", eg, gain)
        `CHK("pre", 0, pre)
        n = 1;
        while (boot !== 1'b1 && n < 100) begin @(negedge mclk); n++; end
        `CHK("boot_cnt", NCYC + 1, n)
        check_res(eg, 0, ep);
    endtask

    task t_straps;
        int cd[4] = '{0, 3, 2, 1};
        int ep[4] = '{1, 2, 2, 2};
        int eg[4] = '{122, 119, 49, 23};
        int kz[4] = '{10000, 16000, 30000, 60000};
        for (int i = 0; i < 4; i++) begin
            do_boot(1'b0, cd[i][1:0], kz[i], 1'b0, ep[i], eg[i]);
        end
    endtask

    // back-to-back writes, last wins; then a loop gain that puts the intermediate frequency out of range
    task t_write;
        wpost = 3'h3; wgain = 12'h0063; wpre = 6'h01; wr = 1'b1;
        @(negedge mclk);
        wpost = 3'h1; wgain = 12'h003F; wpre = 6'h00;
        @(negedge mclk);
        wr = 1'b0;
        @(negedge mclk);
        `CHK("wr_gain", 63, gain)
        `CHK("wr_post", 1, post)
        repeat (4) @(negedge mclk);
        check_res(63, 0, 1);
        wgain = 12'h0000; wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
        repeat (4) @(negedge mclk);
        check_res(0, 0, 1);
        `CHK("range_hit", 1'b1, rerr)
    endtask

    // timer and rtc pace, then the slow oscillator in low power
    task t_counters;
        int n;
        t0 = timer; r0 = rtc;
        repeat (10) @(negedge mclk);
        `CHK("timer", t0 + 50, timer)
        `CHK("rtc", r0 + 10, rtc)
        lp = 1'b1;
        n = 0;
        while (tick !== 1'b1 && n < 700) begin @(negedge mclk); n++; end
        @(negedge mclk);
        r0 = rtc; n = 1;
        do begin @(negedge mclk); n++; end while (tick !== 1'b1 && n < 700);
        `CHK("tick_gap", 640, n)
        @(negedge mclk);
        `CHK("rtc_lp", r0 + 1, rtc)
        lp = 1'b0;
    endtask

    task finish_test;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // cut a hang short well past the expected run of under two thousand cycles
    initial begin
        repeat (10000) @(posedge mclk);
        errors++;
        finish_test;
    end

    initial begin
        t_straps;
        do_boot(1'b1, 2'h3, 9000, 1'b1, 2, 119); // early write ignored
        t_write;
        t_counters;
        finish_test;
    end
endmodule
